//--- seq_pkg.sv
package seq_pkg;
  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 40000;
  // Fixed delays, nanoseconds as printed
  localparam int unsigned INITIAL_DELAY_NS = 1100000;
  localparam int unsigned BOOT_HOLD_NS = 93000;
  localparam int unsigned READY_DELAY_NS = 93000;
  // Derived cycle counts, truncated to whole cycles (typical figures)
  localparam int unsigned INITIAL_DELAY_CYC = (INITIAL_DELAY_NS * 4) / 100;
  localparam int unsigned BOOT_HOLD_CYC = (BOOT_HOLD_NS * 4) / 100;
  localparam int unsigned READY_DELAY_CYC = (READY_DELAY_NS * 4) / 100;
  // Reference DAC: one code is one 6.25mV step
  localparam int unsigned DAC_W = 8;
  localparam logic [DAC_W-1:0] DAC_ZERO = 8'h00;
  // 1.1V boot = 176 steps of 6.25mV
  localparam logic [DAC_W-1:0] BOOT_CODE = 8'hb0;
  // Oscillator period default in clocks (ramp step interval)
  localparam int unsigned STEP_CYC = 1600;
  // Lower-gate rail level selection
  typedef enum logic [1:0] {RAIL_HIGH = 2'h0, RAIL_LOW_GND = 2'h1,
                            RAIL_LOW_BIAS = 2'h2} rail_level_t;
  // Gate drive bundle
  typedef struct packed {
    logic [2:0] upper_gate_drive;
    logic [2:0] lower_gate_drive;
  } gates_t;
endpackage

//--- step_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Free divider giving one-cycle step pulses while enabled
module step_timer
  import seq_pkg::*;
#(
  parameter int unsigned PERIOD = STEP_CYC
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  output logic tick
);
  // Counter cleared when idle so the first step is a full period
  logic [15:0] count;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count == 16'(PERIOD - 1))
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- softstart_power_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module softstart_power_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned INIT_CYC = INITIAL_DELAY_CYC,
  parameter int unsigned HOLD_CYC = BOOT_HOLD_CYC,
  parameter int unsigned RDY_CYC = READY_DELAY_CYC,
  parameter int unsigned OSC_CYC = STEP_CYC
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Release conditions (comparator outputs)
  input wire logic bias_por_ok,
  input wire logic enable_above_thr,
  input wire logic driver_rails_ok,
  // Processor side
  input wire logic [DAC_W-1:0] voltage_id_code,
  input wire logic voltage_id_valid,
  input wire logic power_state_low_n,
  // Analog feedback compare: feedback above reference DAC
  input wire logic feedback_above_ref,
  // Soft-start strap tied to bias (1) or ground (0)
  input wire logic ss_strap_to_bias,
  // Regulation loop PWM request per phase
  input wire logic [2:0] pwm_high,
  // Outputs
  output gates_t gates,
  output logic [DAC_W-1:0] ref_dac,
  output logic regulator_ready,
  output rail_level_t lower_gate_level_select,
  output logic drives_enabled
);
  // Sequencer states
  typedef enum logic [2:0] {S_SHUT, S_DELAY, S_RAMP1, S_HOLD, S_RAMP2, S_READYDLY,
                            S_RUN} state_t;
  state_t state;
  // Timer for fixed delays; wide enough for the initial delay
  logic [31:0] timer;
  // Code latched at end of boot hold
  logic [DAC_W-1:0] target;
  // Step pulse from the oscillator divider
  logic tick;
  // All release conditions together
  logic release_ok;
  assign release_ok = bias_por_ok && enable_above_thr && driver_rails_ok;
  // Ramps active
  logic ramping;
  assign ramping = (state == S_RAMP1) || (state == S_RAMP2);

  // Step one code toward a goal
  function automatic logic [DAC_W-1:0] step_to(input logic [DAC_W-1:0] cur,
                                                input logic [DAC_W-1:0] goal);
    if (cur < goal)
      step_to = cur + 8'h01;
    else if (cur > goal)
      step_to = cur - 8'h01;
    else
      step_to = cur;
  endfunction

  step_timer #(.PERIOD(OSC_CYC)) u_step (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(ramping),
    .tick(tick)
  );

  // Main sequence; a lost condition aborts from any state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_SHUT;
      timer <= 32'h0;
      target <= DAC_ZERO;
      ref_dac <= DAC_ZERO;
    end
    else if (!release_ok)
    begin
      // Full restart once conditions return
      state <= S_SHUT;
      timer <= 32'h0;
      ref_dac <= DAC_ZERO;
    end
    else
    begin
      case (state)
        S_SHUT:
        begin
          state <= S_DELAY;
          timer <= 32'h0;
        end
        S_DELAY:
        begin
          // Fixed delay before any ramp
          if (timer == 32'(INIT_CYC - 1))
          begin
            state <= S_RAMP1;
            timer <= 32'h0;
          end
          else
            timer <= timer + 32'h1;
        end
        S_RAMP1:
        begin
          if (ref_dac == BOOT_CODE)
            state <= S_HOLD;
          else if (tick)
            ref_dac <= step_to(ref_dac, BOOT_CODE);
        end
        S_HOLD:
        begin
          // Code is read only at the end of the hold
          if (timer == 32'(HOLD_CYC - 1))
          begin
            timer <= 32'h0;
            if (voltage_id_valid)
            begin
              target <= voltage_id_code;
              state <= S_RAMP2;
            end
          end
          else
            timer <= timer + 32'h1;
        end
        S_RAMP2:
        begin
          if (ref_dac == target)
            state <= S_READYDLY;
          else if (tick)
            ref_dac <= step_to(ref_dac, target);
        end
        S_READYDLY:
        begin
          if (timer == 32'(RDY_CYC - 1))
          begin
            state <= S_RUN;
            timer <= 32'h0;
          end
          else
            timer <= timer + 32'h1;
        end
        S_RUN:
          state <= S_RUN;
        default:
          state <= S_SHUT;
      endcase
    end
  end

  // Ready only after the final delay; drops at once on abort
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      regulator_ready <= 1'b0;
    else
      regulator_ready <= release_ok && (state == S_RUN);
  end

  // Pre-bias gating: once the reference passes feedback, stay enabled;
  // pre-charge above target is only released at the end of soft-start
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      drives_enabled <= 1'b0;
    else if (!release_ok || state == S_SHUT || state == S_DELAY)
      drives_enabled <= 1'b0;
    else if (state == S_READYDLY || state == S_RUN)
      drives_enabled <= 1'b1;
    else if (!feedback_above_ref)
      drives_enabled <= 1'b1;
  end

  // Gate outputs; complementary when enabled, all low otherwise
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      gates <= '0;
    else if (!drives_enabled || !release_ok)
      gates <= '0;
    else
    begin
      gates.upper_gate_drive <= pwm_high;
      gates.lower_gate_drive <= ~pwm_high;
    end
  end

  // Channel-1 lower-gate rail level from power state and strap
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      lower_gate_level_select <= RAIL_HIGH;
    else if (power_state_low_n)
      lower_gate_level_select <= RAIL_HIGH;
    else if (ss_strap_to_bias)
      lower_gate_level_select <= RAIL_LOW_BIAS;
    else
      lower_gate_level_select <= RAIL_LOW_GND;
  end

  // Cycles spent in the initial delay, kept only for the length check;
  // counted apart from the sequencer timer so a wrong exit compare shows
  logic [31:0] delay_seen;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      delay_seen <= 32'h0;
    else if (state == S_DELAY)
      delay_seen <= delay_seen + 32'h1;
    else
      delay_seen <= 32'h0;
  end

  // Checks
  sequence ready_rise_s;
    $rose(regulator_ready);
  endsequence
  ready_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready_rise_s |-> $past(state) == S_RUN)
    else $error("ready rose outside run");
  shut_gates_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_SHUT) |=> gates == '0)
    else $error("gates active in shutdown");
  lost_cond_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !release_ok |=> state == S_SHUT && !regulator_ready)
    else $error("no shutdown on lost condition");
  delay_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_RAMP1 && $past(state) == S_DELAY) |-> delay_seen == 32'(INIT_CYC))
    else $error("initial delay wrong length");
  step_size_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ramping && release_ok && $changed(ref_dac) && $past(release_ok))
      |-> (ref_dac == $past(ref_dac) + 8'h01 || ref_dac == $past(ref_dac) - 8'h01))
    else $error("dac step not one code");
  step_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ramping && $past(release_ok) && release_ok && $changed(ref_dac)) |-> $past(tick))
    else $error("dac step without tick");
  boot_reach_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(state) == S_RAMP1 && state == S_HOLD) |-> ref_dac == BOOT_CODE)
    else $error("hold entered off boot code");
  rail_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    power_state_low_n |=> lower_gate_level_select == RAIL_HIGH)
    else $error("rail not high in normal power");
  prebias_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ramping && feedback_above_ref && !drives_enabled && release_ok) |=> !drives_enabled)
    else $error("drives enabled above feedback");
endmodule
`default_nettype wire

//--- proc_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
// Processor and power stage as the sequencer sees them
module proc_stage_model
  import seq_pkg::*;
(
  // Reference from the sequencer
  input wire logic [DAC_W-1:0] ref_dac,
  // Scenario settings
  input wire logic [DAC_W-1:0] target,
  input wire logic [DAC_W-1:0] precharge,
  input wire logic code_ok,
  // Answers
  output logic [DAC_W-1:0] voltage_id_code,
  output logic voltage_id_valid,
  output logic feedback_above_ref
);
  // Code settles once boot level is reached, early in the hold; before
  // that the pins carry the inverse so an early read shows up
  always_comb
  begin
    voltage_id_code = (ref_dac >= BOOT_CODE) ? target : ~target;
    voltage_id_valid = code_ok && (ref_dac >= BOOT_CODE);
  end
  // Output rests at its pre-charged level until the reference passes it
  assign feedback_above_ref = precharge > ref_dac;
endmodule
`default_nettype wire

//--- test_softstart_power_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, a, b); end end
module test_softstart_power_sequencer
  import seq_pkg::*;
;
  // Short counts keep the run brief
  localparam int INIT = 20;
  localparam int HOLD = 10;
  localparam int RDY = 10;
  localparam int OSC = 4;
  localparam logic [DAC_W-1:0] TGT = 8'hb8;
  // Clock, reset and stimulus
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bias = 1'b0, en = 1'b0, rails = 1'b0, psi_n = 1'b1, strap = 1'b0;
  logic code_ok = 1'b1;
  logic [DAC_W-1:0] pre = 8'h00, prev = 8'h00;
  // Design outputs and model answers
  logic [DAC_W-1:0] code, ref_dac;
  logic valid, fb_above, ready, drv;
  gates_t gates;
  rail_level_t rail;
  int miscompares = 0, comparisons = 0, n;
  always #12.5 core_clk = ~core_clk;
  softstart_power_sequencer #(.INIT_CYC(INIT), .HOLD_CYC(HOLD), .RDY_CYC(RDY),
    .OSC_CYC(OSC)) uut (.core_clk(core_clk), .rst_n(rst_n), .bias_por_ok(bias),
    .enable_above_thr(en), .driver_rails_ok(rails), .voltage_id_code(code),
    .voltage_id_valid(valid), .power_state_low_n(psi_n),
    .feedback_above_ref(fb_above), .ss_strap_to_bias(strap), .pwm_high(3'h5),
    .gates(gates), .ref_dac(ref_dac), .regulator_ready(ready),
    .lower_gate_level_select(rail), .drives_enabled(drv));
  proc_stage_model partner (.ref_dac(ref_dac), .target(TGT), .precharge(pre),
    .code_ok(code_ok), .voltage_id_code(code), .voltage_id_valid(valid),
    .feedback_above_ref(fb_above));
  // Every rise of the reference is a single code; sampled on the falling
  // edge so the code launched at the rising edge has settled
  always @(negedge core_clk)
  begin
    if (rst_n && ref_dac > prev) `CHK(ref_dac, prev + 8'h01)
    prev <= ref_dac;
  end
  // Settled sampling at the falling edge
  task automatic step(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic set_ok(input logic b, input logic e, input logic d);
    @(posedge core_clk);
    bias <= b;
    en <= e;
    rails <= d;
  endtask
  // Bounded wait for a reference code, returning the cycles spent
  task automatic wait_ref(input logic [DAC_W-1:0] v, input int lim);
    n = 0;
    while (ref_dac !== v && n < lim)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < RDY + 8)
    begin
      step(1);
      n++;
    end
  endtask
  // One missing condition at a time keeps everything off
  task automatic t_shutdown();
    for (int i = 0; i < 3; i++)
    begin
      set_ok(i != 0, i != 1, i != 2);
      step(40);
      `CHK(gates, gates_t'(0))
      `CHK({ready, drv, ref_dac}, 10'h000)
    end
  endtask
  // Full start: delay, ramp, hold, code, ramp, ready
  task automatic t_startup();
    set_ok(1, 1, 1);
    step(INIT - 3);
    `CHK(ref_dac, DAC_ZERO)
    wait_ref(8'h01, 12);
    wait_ref(8'h02, 2 * OSC);
    `CHK(n, OSC)
    wait_ref(BOOT_CODE, 200 * OSC);
    `CHK(ref_dac, BOOT_CODE)
    step(HOLD - 3);
    `CHK({ref_dac, ready}, {BOOT_CODE, 1'b0})
    wait_ref(TGT, HOLD + 12 * OSC);
    `CHK({ref_dac, ready}, {TGT, 1'b0})
    step(RDY - 3);
    `CHK(ready, 1'b0)
    wait_ready();
    `CHK(ready, 1'b1)
    // Enabled drives follow the loop request: upper 5, lower its inverse 2
    `CHK({drv, gates}, 7'h6a)
  endtask
  // Losing enable drops everything; an invalid code keeps the boot level
  task automatic t_restart();
    set_ok(1, 0, 1);
    step(2);
    `CHK({ready, drv, gates}, 8'h00)
    // Code turns invalid on the same rising edge that restores enable
    set_ok(1, 1, 1);
    code_ok <= 1'b0;
    wait_ref(BOOT_CODE, INIT + 200 * OSC);
    step(3 * HOLD);
    `CHK({ref_dac, ready}, {BOOT_CODE, 1'b0})
    @(posedge core_clk);
    code_ok <= 1'b1;
    wait_ref(TGT, 2 * HOLD + 12 * OSC);
    `CHK(ref_dac, TGT)
    wait_ready();
    `CHK(ready, 1'b1)
  endtask
  // Rail level from power state and strap
  task automatic t_rail();
    // Bit 2 power state, bit 0 strap: normal, low with ground, low with bias
    logic [2:0] tab [3] = '{3'b100, 3'b000, 3'b001};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      psi_n <= tab[i][2];
      strap <= tab[i][0];
      step(3);
      `CHK(rail, rail_level_t'(i))
    end
  endtask
  // Pre-charged output: drives wait for the reference, or for the end
  task automatic t_prebias();
    set_ok(0, 1, 1);
    pre <= 8'h50;
    set_ok(1, 1, 1);
    wait_ref(8'h40, INIT + 100 * OSC);
    `CHK({drv, gates}, 7'h00)
    wait_ref(8'h60, 40 * OSC);
    `CHK(drv, 1'b1)
    set_ok(0, 1, 1);
    pre <= 8'hff;
    set_ok(1, 1, 1);
    wait_ref(TGT, INIT + 200 * OSC + HOLD);
    `CHK(drv, 1'b0)
    wait_ready();
    `CHK(drv, 1'b1)
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_shutdown();
    t_startup();
    t_restart();
    t_rail();
    t_prebias();
    summarize();
  end
  // Watchdog well past the expected few thousand cycles
  initial
  begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
